// ==== bench/irq_prio_assertions.sv ====
// checker for the priority bank apb answer and field outputs
// assumes clk_en held high by the bench
`timescale 1ns/1ps
module irq_prio_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // fields
  input wire logic [2:0]  capture8_prio,
  input wire logic [19:0] src_enabled,
  input wire logic [7:0]  max_level_onehot
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////
  // zero wait states, one-cycle answer
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  // unimplemented bits and refusals
  unimpl_zero_a: assert property (pready && paddr < 12'h014 |->
    (prdata & 32'hffff_8888) == 32'h0000_0000) else $error("bit not zero");
  unmapped_err_a: assert property (pready && paddr > 12'h014 |->
    pslverr && prdata == 32'h0000_0000) else $error("unmapped accepted");
  mapped_ok_a: assert property (pready && paddr < 12'h014 |->
    !pslverr) else $error("mapped access refused");
  // field behaviour
  reset_level_a: assert property ($rose(presetn) |->
    capture8_prio == 3'h4) else $error("field not level four");
  write_field_a: assert property (pready && pwrite && paddr == 12'h000
    && pstrb[1] |=> capture8_prio == $past(pwdata[14:12]))
    else $error("field not written");
  enable_follow_a: assert property ($past(presetn) |->
    src_enabled[0] == ($past(capture8_prio) != 3'h0))
    else $error("enable wrong");
  top_level_a: assert property (capture8_prio == 3'h7 |=>
    max_level_onehot[7]) else $error("level seven missing");
  cover property (pready && pslverr);
  cover property (pready && pwrite);
  cover property (!src_enabled[0]);
endmodule

bind irq_priority_regs_5_to_9 irq_prio_assertions chk (.*);

// ==== bench/irq_priority_regs_5_to_9_test.sv ====
// self-checking bench for the priority register bank
// assumes the bank and its checker are compiled before it
`timescale 1ns/1ps
module irq_priority_regs_5_to_9_test;
  import irq_prio_pkg::*;
  // bench signals
  logic        pclk = 0, presetn = 0, clk_en = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'h3;
  logic        pready, pslverr;
  prio_field_t capture8_prio, capture7_prio, adc2_done_prio, ext_irq1_prio,
    timer4_prio, compare4_prio, compare3_prio, dma_ch2_done_prio,
    uart2_tx_prio, uart2_rx_prio, ext_irq2_prio, timer5_prio,
    can1_event_prio, can1_rx_ready_prio, spi2_event_prio, spi2_error_prio,
    capture5_prio, capture4_prio, capture3_prio, dma_ch3_done_prio;
  logic [19:0] src_enabled;
  logic [7:0]  max_level_onehot;
  // field g = 4*reg+slot sits at bits 3g+2:3g
  wire [59:0]  flds = {dma_ch3_done_prio, capture3_prio, capture4_prio,
    capture5_prio, spi2_error_prio, spi2_event_prio, can1_rx_ready_prio,
    can1_event_prio, timer5_prio, ext_irq2_prio, uart2_rx_prio,
    uart2_tx_prio, dma_ch2_done_prio, compare3_prio, compare4_prio,
    timer4_prio, ext_irq1_prio, adc2_done_prio, capture7_prio,
    capture8_prio};
  int          err_count = 0, comparisons = 0, cyc = 0;
  logic [33:0] exp_q[$], e;
  prio_reg_t   model[5];
  logic [15:0] rnd = 16'h001b;

  irq_priority_regs_5_to_9 dut (.*);
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // status word model: enables at 27:8, one-hot levels at 7:0
  function automatic logic [31:0] stat_exp();
    logic [31:0] s;
    logic [2:0]  f;
    s = 32'h0000_0000;
    for (int g = 0; g < 20; g++) begin
      f = model[g/4][14-4*(g%4) -: 3];
      if (f != 3'h0) begin
        s[8+g] = 1'b1;
        s[f]   = 1'b1;
      end
    end
    return s;
  endfunction
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // e: bit 33 read data checked, bit 32 error expected
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [33:0] x);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    exp_q.push_back(x);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask
  // release the bus, let fields and summaries settle, compare
  task automatic fields();
    {psel, penable} <= 2'b00;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    for (int g = 0; g < 20; g++) begin
      cmp(flds[3*g +: 3], model[g/4][14-4*(g%4) -: 3]);
      cmp(src_enabled[g], |model[g/4][14-4*(g%4) -: 3]);
    end
    @(posedge pclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // answer monitor: oldest note against each answer
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      if (e[33]) cmp({pslverr, prdata}, e[32:0]);
      else cmp({32'h0, pslverr}, {32'h0, e[32]});
    end
  end
  // hang guard, run needs about a hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    for (int r = 0; r < 5; r++) model[r] = 16'h4444;
    fields();
    for (int r = 0; r < 5; r++) begin
      xfer(0, 12'(4*r), 0, {18'h20000, 16'h4444});
      rnd = nxt(rnd);
      model[r] = rnd & 16'h7777;
      xfer(1, 12'(4*r), {16'hffff, rnd}, 34'h0);
      xfer(0, 12'(4*r), 0, {18'h20000, model[r]});
    end
    fields();
    $display("reset, map and readback test done");
    for (int c = 0; c < 8; c++) begin
      model[0] = {4{1'b0, 3'(c)}};
      xfer(1, 12'h000, {16'h0, model[0]}, 34'h0);
      fields();
      if (c != 0) cmp({32'h0, max_level_onehot[c]}, 33'h1);
    end
    $display("code test done");
    xfer(0, 12'h018, 0, {2'b11, 32'h0});
    xfer(1, 12'h020, 32'h7777, {2'b01, 32'h0});
    xfer(1, 12'h014, 32'h0, {2'b01, 32'h0});
    xfer(0, 12'h000, 0, {18'h20000, model[0]});
    fields();
    xfer(0, 12'h014, 0, {2'b10, stat_exp()});
    $display("refusal and status test done");
    // only byte lane 0: the upper byte must keep its fields
    pstrb <= 4'h1;
    model[1] = model[1] & 16'h7700;
    xfer(1, 12'h004, 32'h0, 34'h0);
    pstrb <= 4'h3;
    xfer(0, 12'h004, 0, {18'h20000, model[1]});
    fields();
    $display("byte lane test done");
    report_and_stop();
  end
endmodule

// ==== core/irq_priority_regs_5_to_9.sv ====
// apb register bank of five interrupt priority registers
// assumes apb3 master, one clock, async active-low reset
`timescale 1ns/1ps
`include "irq_prio_consts.svh"

////////////////////////////////////////////////////////////////////////
// How it works
// - code 111 means level 7, highest
// - code 001 lowest level, codes linear between
// - code 000 disables the source
// - bits 15, 11, 7, 3 read zero
// - every field resets to 100, level four
// - ctrl5: capture8, capture7, adc2, ext irq1
// - ctrl6: timer4, compare4, compare3, dma2
// - ctrl7: uart2 tx, uart2 rx, ext2, timer5
// - ctrl8: can1 event, can1 rx, spi2, spi2 error
// - ctrl9: capture5, capture4, capture3, dma3
// - fields read back last written value
module irq_priority_regs_5_to_9
  import irq_prio_pkg::*;
(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // priority codes to the arbiter
  output logic      [2:0]  capture8_prio,
  output logic      [2:0]  capture7_prio,
  output logic      [2:0]  adc2_done_prio,
  output logic      [2:0]  ext_irq1_prio,
  output logic      [2:0]  timer4_prio,
  output logic      [2:0]  compare4_prio,
  output logic      [2:0]  compare3_prio,
  output logic      [2:0]  dma_ch2_done_prio,
  output logic      [2:0]  uart2_tx_prio,
  output logic      [2:0]  uart2_rx_prio,
  output logic      [2:0]  ext_irq2_prio,
  output logic      [2:0]  timer5_prio,
  output logic      [2:0]  can1_event_prio,
  output logic      [2:0]  can1_rx_ready_prio,
  output logic      [2:0]  spi2_event_prio,
  output logic      [2:0]  spi2_error_prio,
  output logic      [2:0]  capture5_prio,
  output logic      [2:0]  capture4_prio,
  output logic      [2:0]  capture3_prio,
  output logic      [2:0]  dma_ch3_done_prio,
  // per-source enable, OR of all sources' one-hot levels
  output logic      [19:0] src_enabled,
  output logic      [7:0]  max_level_onehot
);

  ////////////////////////////////////////////////////////////////////
  // register storage
  prio_reg_t  ctrl [5];
  prio_reg_t  next_ctrl [5];
  apb_state_t state;
  apb_state_t next_state;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [19:0] next_src_enabled;
  logic [7:0]  next_max_level;
  logic [2:0]  sel_idx;
  logic        sel_hit;
  logic        sel_status;
  prio_reg_t   wr_mask;

  // address decode; unmapped words give pslverr
  always_comb begin
    sel_idx    = 3'h0;
    sel_hit    = 1'b0;
    sel_status = 1'b0;
    case (paddr)
      `IRQ_PRIO_OFS_CTRL5: begin sel_idx = 3'h0; sel_hit = 1'b1; end
      `IRQ_PRIO_OFS_CTRL6: begin sel_idx = 3'h1; sel_hit = 1'b1; end
      `IRQ_PRIO_OFS_CTRL7: begin sel_idx = 3'h2; sel_hit = 1'b1; end
      `IRQ_PRIO_OFS_CTRL8: begin sel_idx = 3'h3; sel_hit = 1'b1; end
      `IRQ_PRIO_OFS_CTRL9: begin sel_idx = 3'h4; sel_hit = 1'b1; end
      `IRQ_PRIO_OFS_STATUS: begin
        sel_status = 1'b1;
      end
      default: begin
        sel_hit = 1'b0;
      end
    endcase
    // only the two low byte lanes carry register bits
    wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & `IRQ_PRIO_IMPL_MASK;
  end

  ////////////////////////////////////////////////////////////////////
  // field decoders, one per source
  prio_field_if fld [20] ();
  genvar g;
  generate
    for (g = 0; g < 20; g++) begin : g_dec
      // field g/4 register, slot 3-(g%4) from the top down
      assign fld[g].code = ctrl[g/4][(3 - g%4)*4 +: 3];
      prio_field_decode u_dec (
        .fld (fld[g])
      );
    end
  endgenerate

  logic [19:0] dec_en;
  logic [7:0]  dec_or [21];
  assign dec_or[0] = 8'h00;
  generate
    for (g = 0; g < 20; g++) begin : g_sum
      assign dec_en[g]    = fld[g].enabled;
      assign dec_or[g+1]  = dec_or[g] | fld[g].level_onehot;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // next values: apb fsm, register writes, read data
  always_comb begin
    next_state   = state;
    next_ctrl    = ctrl;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (state)
      APB_IDLE: begin
        // answer in the first access cycle: zero wait states
        if (psel && !penable) begin
          next_state  = APB_ACCESS;
          next_pready = 1'b1;
          next_pslverr = !(sel_hit || (sel_status && !pwrite));
          next_prdata = 32'h0000_0000;
          if (!pwrite && sel_hit) begin
            next_prdata = {16'h0000,
                           ctrl[sel_idx] & `IRQ_PRIO_IMPL_MASK};
          end else if (!pwrite && sel_status) begin
            next_prdata = {4'h0, src_enabled, max_level_onehot};
          end
        end
      end
      APB_ACCESS: begin
        // write lands on the completing edge, pready high
        if (psel && penable && pwrite && sel_hit) begin
          next_ctrl[sel_idx] = (ctrl[sel_idx] & ~wr_mask)
                             | (pwdata[15:0] & wr_mask);
        end
        next_state = APB_IDLE;
      end
      default: begin
        next_state = APB_IDLE;
      end
    endcase
    next_src_enabled = dec_en;
    next_max_level   = dec_or[20];
  end

  // registers; reset loads level four into every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) begin
        ctrl[i] <= `IRQ_PRIO_REG_RST;
      end
      state            <= APB_IDLE;
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      src_enabled      <= 20'h0_0000;
      max_level_onehot <= 8'h00;
    end else if (clk_en) begin
      ctrl             <= next_ctrl;
      state            <= next_state;
      prdata           <= next_prdata;
      pready           <= next_pready;
      pslverr          <= next_pslverr;
      src_enabled      <= next_src_enabled;
      max_level_onehot <= next_max_level;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // field outputs; taken from the register so always registered
  always_comb begin
    capture8_prio      = ctrl[0][`IRQ_PRIO_POS_F3 +: 3];
    capture7_prio      = ctrl[0][`IRQ_PRIO_POS_F2 +: 3];
    adc2_done_prio     = ctrl[0][`IRQ_PRIO_POS_F1 +: 3];
    ext_irq1_prio      = ctrl[0][`IRQ_PRIO_POS_F0 +: 3];
    timer4_prio        = ctrl[1][`IRQ_PRIO_POS_F3 +: 3];
    compare4_prio      = ctrl[1][`IRQ_PRIO_POS_F2 +: 3];
    compare3_prio      = ctrl[1][`IRQ_PRIO_POS_F1 +: 3];
    dma_ch2_done_prio  = ctrl[1][`IRQ_PRIO_POS_F0 +: 3];
    uart2_tx_prio      = ctrl[2][`IRQ_PRIO_POS_F3 +: 3];
    uart2_rx_prio      = ctrl[2][`IRQ_PRIO_POS_F2 +: 3];
    ext_irq2_prio      = ctrl[2][`IRQ_PRIO_POS_F1 +: 3];
    timer5_prio        = ctrl[2][`IRQ_PRIO_POS_F0 +: 3];
    can1_event_prio    = ctrl[3][`IRQ_PRIO_POS_F3 +: 3];
    can1_rx_ready_prio = ctrl[3][`IRQ_PRIO_POS_F2 +: 3];
    spi2_event_prio    = ctrl[3][`IRQ_PRIO_POS_F1 +: 3];
    spi2_error_prio    = ctrl[3][`IRQ_PRIO_POS_F0 +: 3];
    capture5_prio      = ctrl[4][`IRQ_PRIO_POS_F3 +: 3];
    capture4_prio      = ctrl[4][`IRQ_PRIO_POS_F2 +: 3];
    capture3_prio      = ctrl[4][`IRQ_PRIO_POS_F1 +: 3];
    dma_ch3_done_prio  = ctrl[4][`IRQ_PRIO_POS_F0 +: 3];
  end

endmodule

// ==== core/prio_field_decode.sv ====
// decodes one 3-bit priority field into enable and one-hot level
// assumes the code comes straight from a register
`timescale 1ns/1ps
module prio_field_decode (
  // field
  prio_field_if.dec_side fld
);
  // level n sets bit n; code 000 leaves the source off entirely
  always_comb begin
    fld.enabled      = (fld.code != 3'h0);
    fld.level_onehot = 8'h00;
    if (fld.code != 3'h0) begin
      fld.level_onehot[fld.code] = 1'b1;
    end
  end
endmodule

// ==== inc/irq_prio_consts.svh ====
// constants for the interrupt priority register bank 5..9
// assumes a 32-bit apb slave with word-aligned registers
`ifndef IRQ_PRIO_CONSTS_SVH
`define IRQ_PRIO_CONSTS_SVH

// byte addresses of the five priority registers
`define IRQ_PRIO_OFS_CTRL5   12'h000
`define IRQ_PRIO_OFS_CTRL6   12'h004
`define IRQ_PRIO_OFS_CTRL7   12'h008
`define IRQ_PRIO_OFS_CTRL8   12'h00C
`define IRQ_PRIO_OFS_CTRL9   12'h010
// per-source enables and one-hot level summary, read only
`define IRQ_PRIO_OFS_STATUS  12'h014

// field positions (low bit of each 3-bit field)
`define IRQ_PRIO_POS_F3      12
`define IRQ_PRIO_POS_F2      8
`define IRQ_PRIO_POS_F1      4
`define IRQ_PRIO_POS_F0      0
// implemented bits of a priority register
`define IRQ_PRIO_IMPL_MASK   16'h7777

// reset pattern of every field: level 4
`define IRQ_PRIO_FIELD_RST   3'h4
`define IRQ_PRIO_REG_RST     16'h4444

// field codes
`define IRQ_PRIO_OFF         3'h0
`define IRQ_PRIO_LOWEST      3'h1
`define IRQ_PRIO_HIGHEST     3'h7

`endif

// ==== inc/irq_prio_pkg.sv ====
// types for the interrupt priority register bank
// assumes irq_prio_consts.svh is on the include path
package irq_prio_pkg;
  typedef logic [2:0]  prio_field_t;
  typedef logic [15:0] prio_reg_t;
  typedef logic [7:0]  onehot_level_t;
  typedef enum logic [1:0] {
    APB_IDLE,
    APB_ACCESS
  } apb_state_t;
endpackage

// ==== inc/prio_field_if.sv ====
// carrier between bank top and the per-field decoder
// assumes one instance per priority field
`timescale 1ns/1ps
interface prio_field_if;
  logic [2:0] code;
  logic       enabled;
  logic [7:0] level_onehot;
  modport reg_side (output code, input enabled, input level_onehot);
  modport dec_side (input code, output enabled, output level_onehot);
endinterface
